// ===== bench/sagc_config_sva.sv
/*
  Concurrent checks on the ports of the gain and AGC configuration top.
  Assumes it is bound into that top and shares its single clock and reset.
*/
`timescale 1ns/1ps
module sagc_config_sva (
  input wire logic        sys_clk_i,                    // Clock.
  input wire logic        nrst_i,                       // Reset, active low.
  input wire logic [7:0]  reg_addr_i,                   // Address.
  input wire logic        reg_wr_i,                     // Write strobe.
  input wire logic        reg_rd_i,                     // Read strobe.
  input wire logic [7:0]  reg_rdata_o,                  // Read data.
  input wire logic        flicker_detect_enable_i,      // Flicker enable.
  input wire logic        agc_enable_i,                 // AGC enable.
  input wire logic [7:0]  integration_step_count_i,     // Step count.
  input wire logic [15:0] integration_step_size_i,      // Step size.
  input wire logic [7:0]  flicker_steps_low_i,          // Flicker steps low.
  input wire logic        spectral_data_valid_i,        // Data strobe.
  input wire logic [15:0] spectral_data_i,              // Spectral data.
  input wire logic        flicker_result_valid_i,       // Result strobe.
  input wire logic        flicker_result_i,             // Raw result.
  input wire logic [29:0] channel_gain_code_o,          // Gain codes.
  input wire logic        adc5_own_timing_o,            // Own timing.
  input wire logic [10:0] flicker_integration_steps_o,  // Flicker steps.
  input wire logic [28:0] agc_upper_threshold_o,        // Upper threshold.
  input wire logic [28:0] agc_lower_threshold_o,        // Lower threshold.
  input wire logic        flicker_status_o,             // Filtered status.
  input wire logic        flicker_status_change_o       // Flip pulse.
);
  logic [4:0] g0;
  // Converter zero carries the spectral gain; the others are compared against it.
  assign g0 = channel_gain_code_o[4:0];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // The select field is not visible here, so any of the four fractions from the base up is accepted.
  function automatic logic thr_ok(input logic [28:0] t, input logic [7:0] c, input logic [15:0] s, input logic [2:0] b);
    logic [28:0] fs;
    fs = ({21'h0, c} + 29'h1) * ({13'h0, s} + 29'h1);
    thr_ok = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (t == ((fs * ({26'h0, b} + 29'(k))) >> 3)) thr_ok = 1'b1;
    end
  endfunction
  // Bits that must read as zero at each address; unmapped reads are all zero.
  function automatic logic [7:0] rsv(input logic [7:0] a);
    case (a)
      8'hAA: rsv = 8'hE0;
      8'hB3: rsv = 8'h08;
      8'hDA: rsv = 8'h00;
      default: rsv = 8'hFF;
    endcase
  endfunction
  // The gain output only mirrors the register when nothing moved it one cycle earlier.
  sequence settled_s;
    $past(nrst_i) && !$past(reg_wr_i) && !$past(spectral_data_valid_i);
  endsequence
  sequence agc_take_s;
    agc_enable_i && spectral_data_valid_i && !reg_wr_i;
  endsequence
  agc_down_a: assert property (
    settled_s ##0 agc_take_s ##0 (spectral_data_i >= agc_upper_threshold_o && g0 != 5'h00) |-> ##2 g0 == $past(g0, 2) - 5'h01)
    else $error("Spectral gain did not step down.");
  agc_up_a: assert property (
    settled_s ##0 agc_take_s ##0 (spectral_data_i < agc_upper_threshold_o && spectral_data_i < agc_lower_threshold_o
    && g0 < 5'h0A) |-> ##2 g0 == $past(g0, 2) + 5'h01) else $error("Spectral gain did not step up.");
  thr_upper_a: assert property (
    $past(nrst_i) |-> thr_ok(agc_upper_threshold_o, $past(integration_step_count_i), $past(integration_step_size_i), 3'h4))
    else $error("Upper threshold off.");
  thr_lower_a: assert property (
    $past(nrst_i) |-> thr_ok(agc_lower_threshold_o, $past(integration_step_count_i), $past(integration_step_size_i), 3'h1))
    else $error("Lower threshold off.");
  own_timing_a: assert property ($past(nrst_i) |-> adc5_own_timing_o == $past(flicker_detect_enable_i))
    else $error("Own timing flag wrong.");
  steps_low_a: assert property ($past(nrst_i) |-> flicker_integration_steps_o[7:0] == $past(flicker_steps_low_i))
    else $error("Flicker steps low byte wrong.");
  gain_slots_a: assert property (channel_gain_code_o[24:5] == {4{g0}})
    else $error("Spectral gain slots differ.");
  slot_follow_a: assert property (
    $past(nrst_i) && !$past(flicker_detect_enable_i) && !$past(flicker_detect_enable_i, 2) |-> channel_gain_code_o[29:25] == g0)
    else $error("Converter five ignores common gain.");
  flip_pulse_a: assert property ($past(nrst_i) |-> flicker_status_change_o == (flicker_status_o != $past(flicker_status_o)))
    else $error("Flip pulse does not match status.");
  flip_cause_a: assert property (
    flicker_status_change_o |-> $past(flicker_result_valid_i, 2) && flicker_status_o == $past(flicker_result_i, 2))
    else $error("Status flipped without a result.");
  rsv_read_a: assert property (reg_rd_i |=> (reg_rdata_o & rsv($past(reg_addr_i))) == 8'h00)
    else $error("Reserved bits read nonzero.");
endmodule // sagc_config_sva

// ===== bench/sagc_host_model.sv
/*
  Host side of the register port: issues one-cycle write and read strobes.
  Assumes the same clock as the device and that the caller keeps transfers apart.
*/
`timescale 1ns/1ps
module sagc_host_model (
  input  wire logic       sys_clk_i,   // Clock.
  output logic      [7:0] reg_addr_o,  // Address.
  output logic      [7:0] reg_wdata_o, // Write data.
  output logic            reg_wr_o,    // Write strobe.
  output logic            reg_rd_o,    // Read strobe.
  input  wire logic [7:0] reg_rdata_i  // Read data.
);
  // Idle bus at time zero.
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Address and data are inverted once released so a stale value can never pass for a live one.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  // Read data is registered at the taking edge, so it is picked up at the edge after it.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge sys_clk_i);
    d = reg_rdata_i;
  endtask
endmodule // sagc_host_model

// ===== bench/tb.sv
/*
  Self-checking bench for the gain, AGC threshold and flicker persistence configuration top.
  Assumes the host model file and the checker file are compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic        sys_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i, reg_rd_i, flicker_detect_enable_i = 1'b0, st;
  logic        power_on_bit_i = 1'b0, agc_enable_i = 1'b0, spectral_data_valid_i = 1'b0, adc5_own_timing_o;
  logic        flicker_result_valid_i = 1'b0, flicker_result_i = 1'b0, flicker_status_o, flicker_status_change_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rd, integration_step_count_i = 8'h00, flicker_steps_low_i = 8'h00;
  logic [15:0] integration_step_size_i = 16'h0000, spectral_data_i = 16'h0000;
  logic [29:0] channel_gain_code_o;
  logic [10:0] flicker_integration_steps_o;
  logic [28:0] agc_upper_threshold_o, agc_lower_threshold_o;
  logic [31:0] seed = 32'h2434;
  logic [7:0]  adr[4] = '{8'hAA, 8'hB3, 8'hDA, 8'h55};
  logic [7:0]  sh[4] = '{8'h09, 8'hF2, 8'h48, 8'h00};
  int          num_errors = 0, checks = 0, k, n;
  logic [4:0]  g;

  sagc_config_top sagc_config_top_i (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .flicker_detect_enable_i, .power_on_bit_i, .agc_enable_i, .integration_step_count_i, .integration_step_size_i,
    .flicker_steps_low_i, .spectral_data_valid_i, .spectral_data_i, .flicker_result_valid_i, .flicker_result_i,
    .channel_gain_code_o, .adc5_own_timing_o, .flicker_integration_steps_o, .agc_upper_threshold_o,
    .agc_lower_threshold_o, .flicker_status_o, .flicker_status_change_o);
  sagc_host_model sagc_host_model_i (.sys_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

  // Free-running 25 MHz clock.
  always #20 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  // Expected threshold: floor of full scale times k eighths.
  function automatic logic [28:0] thr(input logic [7:0] c, input logic [15:0] s, input logic [2:0] m);
    thr = (({21'h0, c} + 29'h1) * ({13'h0, s} + 29'h1) * {26'h0, m}) >> 3;
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'hAA: msk = 8'h1F;
      8'hB3: msk = 8'hF7;
      8'hDA: msk = 8'hFF;
      default: msk = 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One spectral result, then time for the gain output to follow.
  task automatic pulse(input logic [15:0] d);
    @(posedge sys_clk_i);
    spectral_data_valid_i <= 1'b1;
    spectral_data_i <= d;
    @(posedge sys_clk_i);
    spectral_data_valid_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // A back-to-back run of c equal flicker results.
  task automatic flick(input logic v, input int c);
    repeat (c) begin
      @(posedge sys_clk_i);
      flicker_result_valid_i <= 1'b1;
      flicker_result_i <= v;
    end
    @(posedge sys_clk_i);
    flicker_result_valid_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask

  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    #(40 * 20000);
    num_errors++;
    stop_test();
  end

  // Main sequence: reset values, random configuration, AGC boundaries, persistence codes.
  initial begin
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sagc_host_model_i.read(adr[i], rd);
      chk(rd, sh[i]);
    end
    chk(channel_gain_code_o, {6{5'h09}});
    chk(adc5_own_timing_o, 1'b0);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      @(posedge sys_clk_i);
      flicker_detect_enable_i <= 1'b0;
      power_on_bit_i <= seed[0];
      integration_step_count_i <= seed[31:24];
      integration_step_size_i <= seed[23:8];
      flicker_steps_low_i <= seed[15:8];
      k = seed[3:2];
      sh[k] = seed[11:4] & msk(adr[k]);
      sagc_host_model_i.write(adr[k], seed[11:4]);
      sagc_host_model_i.read(adr[k], rd);
      chk(rd, sh[k]);
      flicker_detect_enable_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk(agc_upper_threshold_o, thr(integration_step_count_i, integration_step_size_i, {1'b1, sh[1][7:6]}));
      chk(agc_lower_threshold_o, thr(integration_step_count_i, integration_step_size_i, 3'h1 + sh[1][5:4]));
      chk(flicker_integration_steps_o, {sh[2][2:0], flicker_steps_low_i});
      chk(channel_gain_code_o, {sh[2][7:3], {5{sh[0][4:0]}}});
      chk(adc5_own_timing_o, 1'b1);
    end
    $display("test random configuration done");
    sagc_host_model_i.write(8'hB3, 8'hF2);
    agc_enable_i <= 1'b1;
    for (int ph = 0; ph < 2; ph++) begin
      integration_step_count_i <= ph ? 8'hFF : 8'h00;
      integration_step_size_i <= ph ? 16'h00FF : 16'h0000;
      g = ph ? 5'h08 : 5'h02;
      sagc_host_model_i.write(8'hAA, {3'h0, g});
      for (int j = 0; j < 4; j++) begin
        seed = xs(seed);
        pulse(ph ? {1'b0, seed[14:0]} : seed[15:0]);
        g = ph ? ((g < 5'h0A) ? g + 5'h01 : g) : ((g > 5'h00) ? g - 5'h01 : g);
        chk(channel_gain_code_o[4:0], g);
      end
    end
    agc_enable_i <= 1'b0;
    $display("test agc steps done");
    for (int f = 0; f < 8; f++) begin
      sagc_host_model_i.write(8'hB3, {5'h1E, f[2:0]});
      n = (f == 0) ? 1 : 1 << (f - 1);
      st = flicker_status_o;
      flick(!st, n - 1);
      flick(st, 1);
      chk(flicker_status_o, st);
      flick(!st, n);
      chk(flicker_status_o, !st);
    end
    $display("test flicker persistence done");
    stop_test();
  end
endmodule // tb

bind sagc_config_top sagc_config_sva sagc_config_sva_i (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .flicker_detect_enable_i, .agc_enable_i, .integration_step_count_i, .integration_step_size_i,
  .flicker_steps_low_i, .spectral_data_valid_i, .spectral_data_i, .flicker_result_valid_i, .flicker_result_i,
  .channel_gain_code_o, .adc5_own_timing_o, .flicker_integration_steps_o, .agc_upper_threshold_o,
  .agc_lower_threshold_o, .flicker_status_o, .flicker_status_change_o);

// ===== pkg/sagc_persist_if.sv
/*
  Carrier between the configuration top and its flicker persistence filter.
  Assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ps
interface sagc_persist_if;
  logic       result_valid;  // One-cycle strobe of a new flicker result.
  logic       result;        // Raw flicker detect result.
  logic [2:0] persist_sel;   // Persistence field.
  logic       status;        // Filtered flicker detect status.
  logic       status_change; // One-cycle pulse when the status flips.

  modport filt (input result_valid, result, persist_sel, output status, status_change);
  modport ctrl (output result_valid, result, persist_sel, input status, status_change);
endinterface

// ===== pkg/sagc_pkg.sv
/*
  Shared constants for the spectral gain, AGC threshold and flicker persistence configuration block:
  register offsets, field positions, reset values and timing figures.
  Assumes nothing of its surroundings; the configuration top refers to it by scoped name.
*/
package sagc_pkg;

  // Register offsets on the device register port.
  localparam logic [7:0] SAGC_SPECTRAL_GAIN_CFG_ADDR   = 8'hAA;
  localparam logic [7:0] SAGC_AGC_THR_PERSIST_ADDR     = 8'hB3;
  localparam logic [7:0] SAGC_FLICKER_GAIN_TIME_ADDR   = 8'hDA;

  // Field positions.
  localparam int SAGC_FLICKER_GAIN_LSB   = 3;
  localparam int SAGC_FLICKER_GAIN_MSB   = 7;
  localparam int SAGC_FLICKER_TIME_MSB   = 2;
  localparam int SAGC_SPECTRAL_GAIN_MSB  = 4;
  localparam int SAGC_AGC_UPPER_LSB      = 6;
  localparam int SAGC_AGC_UPPER_MSB      = 7;
  localparam int SAGC_AGC_LOWER_LSB      = 4;
  localparam int SAGC_AGC_LOWER_MSB      = 5;
  localparam int SAGC_PERSIST_MSB        = 2;

  // Values after reset.
  localparam logic [4:0] SAGC_FLICKER_GAIN_RST  = 5'h09;
  localparam logic [2:0] SAGC_FLICKER_TIME_RST  = 3'h0;
  localparam logic [4:0] SAGC_SPECTRAL_GAIN_RST = 5'h09;
  localparam logic [1:0] SAGC_AGC_UPPER_RST     = 2'h3;
  localparam logic [1:0] SAGC_AGC_LOWER_RST     = 2'h3;
  localparam logic [2:0] SAGC_PERSIST_RST       = 3'h2;

  // Gain code range: code n selects 2^(n-1), code 0 is half gain, top code is 512x.
  localparam logic [4:0] SAGC_GAIN_CODE_MIN = 5'h00;
  localparam logic [4:0] SAGC_GAIN_CODE_MAX = 5'h0A;

  // Number of integrating converters, the last one being the flicker converter.
  localparam int SAGC_NUM_CHANNELS = 6;

  // Integration step time and its length in clock cycles (at least one cycle).
  localparam int SAGC_STEP_TIME_PS   = 2780000;
  localparam int SAGC_CLK_PERIOD_PS  = 40000;
  localparam int SAGC_STEP_CYCLES    = (SAGC_STEP_TIME_PS + SAGC_CLK_PERIOD_PS - 1) / SAGC_CLK_PERIOD_PS;

endpackage

// ===== rtl/sagc_config_top.sv
/*
  Gain, AGC threshold and flicker persistence configuration for six integrating converters.
  Assumes a register port driven by the serial interface logic on the same clock, and that enable,
  power, integration settings and converter results come from logic on the same clock.
*/
`timescale 1ns/1ps
module sagc_config_top (
  input  wire logic        sys_clk_i,                    // System clock, 25 MHz.
  input  wire logic        nrst_i,                       // Asynchronous reset, active low.
  input  wire logic [7:0]  reg_addr_i,                   // Register address.
  input  wire logic [7:0]  reg_wdata_i,                  // Write data.
  input  wire logic        reg_wr_i,                     // Write strobe, one cycle.
  input  wire logic        reg_rd_i,                     // Read strobe, one cycle.
  output logic      [7:0]  reg_rdata_o,                  // Read data, valid the cycle after the strobe.
  input  wire logic        flicker_detect_enable_i,      // Flicker detect enable.
  input  wire logic        power_on_bit_i,               // Device power on.
  input  wire logic        agc_enable_i,                 // Spectral AGC enable.
  input  wire logic [7:0]  integration_step_count_i,     // Common integration step count.
  input  wire logic [15:0] integration_step_size_i,      // Common integration step size code.
  input  wire logic [7:0]  flicker_steps_low_i,          // Low byte of flicker integration steps.
  input  wire logic        spectral_data_valid_i,        // One-cycle strobe of a spectral result.
  input  wire logic [15:0] spectral_data_i,              // Spectral result used by the AGC.
  input  wire logic        flicker_result_valid_i,       // One-cycle strobe of a flicker result.
  input  wire logic        flicker_result_i,             // Raw flicker result.
  output logic      [29:0] channel_gain_code_o,          // Gain code per converter, five bits each.
  output logic             adc5_own_timing_o,            // Converter five uses its own step count.
  output logic      [10:0] flicker_integration_steps_o,  // Steps of 2.78 us for converter five.
  output logic      [28:0] agc_upper_threshold_o,        // Data level at which gain drops.
  output logic      [28:0] agc_lower_threshold_o,        // Data level below which gain rises.
  output logic             flicker_status_o,             // Filtered flicker detect status.
  output logic             flicker_status_change_o       // One-cycle pulse when the status flips.
);

  // Register fields.
  logic [4:0]  spectral_gain_code_ff;
  logic [4:0]  nxt_spectral_gain_code;
  logic [4:0]  flicker_gain_code_ff;
  logic [4:0]  nxt_flicker_gain_code;
  logic [2:0]  flicker_steps_high_ff;
  logic [2:0]  nxt_flicker_steps_high;
  logic [1:0]  agc_upper_threshold_sel_ff;
  logic [1:0]  nxt_agc_upper_threshold_sel;
  logic [1:0]  agc_lower_threshold_sel_ff;
  logic [1:0]  nxt_agc_lower_threshold_sel;
  logic [2:0]  flicker_persistence_sel_ff;
  logic [2:0]  nxt_flicker_persistence_sel;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;

  // Derived outputs, all registered.
  logic [29:0] gain_out_ff;
  logic [29:0] nxt_gain_out;
  logic        own_timing_ff;
  logic        nxt_own_timing;
  logic [10:0] fl_steps_ff;
  logic [10:0] nxt_fl_steps;
  logic [28:0] upper_thr_ff;
  logic [28:0] nxt_upper_thr;
  logic [28:0] lower_thr_ff;
  logic [28:0] nxt_lower_thr;
  logic        fl_status_ff;
  logic        fl_change_ff;

  logic [25:0] full_scale;
  logic [28:0] data_ext;
  logic [4:0]  adc5_gain;

  sagc_persist_if pif ();

  // Full scale and the two thresholds as eighths of it: upper is (4+sel)/8, lower is (1+sel)/8.
  always_comb begin
    full_scale    = 26'({1'b0, integration_step_count_i} + 9'h001) * 26'({1'b0, integration_step_size_i} + 17'h00001);
    nxt_upper_thr = 29'((29'(full_scale) * (29'h4 + 29'(agc_upper_threshold_sel_ff))) >> 3);
    nxt_lower_thr = 29'((29'(full_scale) * (29'h1 + 29'(agc_lower_threshold_sel_ff))) >> 3);
    data_ext      = 29'(spectral_data_i);
  end

  // Register writes and AGC steps. A host write in the same cycle as an AGC step wins, so software
  // always sees the value it wrote; the AGC uses last cycle's thresholds, a one-cycle lag.
  always_comb begin
    nxt_spectral_gain_code      = spectral_gain_code_ff;
    nxt_flicker_gain_code       = flicker_gain_code_ff;
    nxt_flicker_steps_high      = flicker_steps_high_ff;
    nxt_agc_upper_threshold_sel = agc_upper_threshold_sel_ff;
    nxt_agc_lower_threshold_sel = agc_lower_threshold_sel_ff;
    nxt_flicker_persistence_sel = flicker_persistence_sel_ff;
    if (agc_enable_i && spectral_data_valid_i) begin
      if ((data_ext >= upper_thr_ff) && (spectral_gain_code_ff > sagc_pkg::SAGC_GAIN_CODE_MIN)) begin
        nxt_spectral_gain_code = spectral_gain_code_ff - 5'h01;
      end else if ((data_ext < lower_thr_ff) && (spectral_gain_code_ff < sagc_pkg::SAGC_GAIN_CODE_MAX)) begin
        nxt_spectral_gain_code = spectral_gain_code_ff + 5'h01;
      end
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        sagc_pkg::SAGC_SPECTRAL_GAIN_CFG_ADDR: begin
          nxt_spectral_gain_code = reg_wdata_i[sagc_pkg::SAGC_SPECTRAL_GAIN_MSB:0];
        end
        sagc_pkg::SAGC_AGC_THR_PERSIST_ADDR: begin
          nxt_agc_upper_threshold_sel = reg_wdata_i[sagc_pkg::SAGC_AGC_UPPER_MSB:sagc_pkg::SAGC_AGC_UPPER_LSB];
          nxt_agc_lower_threshold_sel = reg_wdata_i[sagc_pkg::SAGC_AGC_LOWER_MSB:sagc_pkg::SAGC_AGC_LOWER_LSB];
          nxt_flicker_persistence_sel = reg_wdata_i[sagc_pkg::SAGC_PERSIST_MSB:0];
        end
        sagc_pkg::SAGC_FLICKER_GAIN_TIME_ADDR: begin
          nxt_flicker_gain_code  = reg_wdata_i[sagc_pkg::SAGC_FLICKER_GAIN_MSB:sagc_pkg::SAGC_FLICKER_GAIN_LSB];
          nxt_flicker_steps_high = reg_wdata_i[sagc_pkg::SAGC_FLICKER_TIME_MSB:0];
        end
        default: begin
          // Unmapped writes change nothing; read data belongs to the read process alone.
        end
      endcase
    end
  end

  // Read data; unmapped addresses and reserved bits return zero.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        sagc_pkg::SAGC_SPECTRAL_GAIN_CFG_ADDR: nxt_rdata = {3'h0, spectral_gain_code_ff};
        sagc_pkg::SAGC_AGC_THR_PERSIST_ADDR:   nxt_rdata = {agc_upper_threshold_sel_ff, agc_lower_threshold_sel_ff,
                                                            1'b0, flicker_persistence_sel_ff};
        sagc_pkg::SAGC_FLICKER_GAIN_TIME_ADDR: nxt_rdata = {flicker_gain_code_ff, flicker_steps_high_ff};
        default:                               nxt_rdata = 8'h00;
      endcase
    end
  end

  // Converter five takes its own gain and timing only with flicker detect enabled.
  always_comb begin
    adc5_gain      = flicker_detect_enable_i ? flicker_gain_code_ff : spectral_gain_code_ff;
    nxt_own_timing = flicker_detect_enable_i;
    // The host keeps the step count still while enabled and powered, so no shadow copy is taken.
    nxt_fl_steps   = {flicker_steps_high_ff, flicker_steps_low_i};
  end

  // Per-converter gain codes; the last slot is the flicker converter.
  genvar ch;
  generate
    for (ch = 0; ch < sagc_pkg::SAGC_NUM_CHANNELS; ch++) begin : g_gain
      assign nxt_gain_out[ch*5 +: 5] = (ch == sagc_pkg::SAGC_NUM_CHANNELS - 1) ? adc5_gain
                                                                               : spectral_gain_code_ff;
    end
  endgenerate

  // Register stage.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spectral_gain_code_ff      <= sagc_pkg::SAGC_SPECTRAL_GAIN_RST;
      flicker_gain_code_ff       <= sagc_pkg::SAGC_FLICKER_GAIN_RST;
      flicker_steps_high_ff      <= sagc_pkg::SAGC_FLICKER_TIME_RST;
      agc_upper_threshold_sel_ff <= sagc_pkg::SAGC_AGC_UPPER_RST;
      agc_lower_threshold_sel_ff <= sagc_pkg::SAGC_AGC_LOWER_RST;
      flicker_persistence_sel_ff <= sagc_pkg::SAGC_PERSIST_RST;
      rdata_ff                   <= 8'h00;
      gain_out_ff                <= 30'h00000000;
      own_timing_ff              <= 1'b0;
      fl_steps_ff                <= 11'h000;
      upper_thr_ff               <= 29'h00000000;
      lower_thr_ff               <= 29'h00000000;
      fl_status_ff               <= 1'b0;
      fl_change_ff               <= 1'b0;
    end else begin
      spectral_gain_code_ff      <= nxt_spectral_gain_code;
      flicker_gain_code_ff       <= nxt_flicker_gain_code;
      flicker_steps_high_ff      <= nxt_flicker_steps_high;
      agc_upper_threshold_sel_ff <= nxt_agc_upper_threshold_sel;
      agc_lower_threshold_sel_ff <= nxt_agc_lower_threshold_sel;
      flicker_persistence_sel_ff <= nxt_flicker_persistence_sel;
      rdata_ff                   <= nxt_rdata;
      gain_out_ff                <= nxt_gain_out;
      own_timing_ff              <= nxt_own_timing;
      fl_steps_ff                <= nxt_fl_steps;
      upper_thr_ff               <= nxt_upper_thr;
      lower_thr_ff               <= nxt_lower_thr;
      fl_status_ff               <= pif.status;
      fl_change_ff               <= pif.status_change;
    end
  end

  // Persistence filter hookup.
  assign pif.result_valid = flicker_result_valid_i;
  assign pif.result       = flicker_result_i;
  assign pif.persist_sel  = flicker_persistence_sel_ff;

  sagc_flicker_persist u_persist (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pif       (pif.filt)
  );

  assign reg_rdata_o                 = rdata_ff;
  assign channel_gain_code_o         = gain_out_ff;
  assign adc5_own_timing_o           = own_timing_ff;
  assign flicker_integration_steps_o = fl_steps_ff;
  assign agc_upper_threshold_o       = upper_thr_ff;
  assign agc_lower_threshold_o       = lower_thr_ff;
  assign flicker_status_o            = fl_status_ff;
  assign flicker_status_change_o     = fl_change_ff;

endmodule // sagc_config_top

// ===== rtl/sagc_flicker_persist.sv
/*
  Flicker detect persistence filter: the status flips only after a run of consecutive differing results.
  Assumes results arrive as one-cycle strobes on the system clock.
*/
`timescale 1ns/1ps
module sagc_flicker_persist (
  input  wire logic  sys_clk_i,  // System clock, 25 MHz.
  input  wire logic  nrst_i,     // Asynchronous reset, active low.
  sagc_persist_if.filt pif       // Results in, filtered status out.
);

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic       status_ff;
  logic       nxt_status;
  logic       change_ff;
  logic       nxt_change;
  logic [6:0] run_len;

  // Run length is 2^(field-1); field 0 is taken as a run of one, since a half result has no meaning.
  always_comb begin
    run_len    = (pif.persist_sel == 3'h0) ? 7'h01 : (7'h01 << (pif.persist_sel - 3'h1));
    nxt_cnt    = cnt_ff;
    nxt_status = status_ff;
    nxt_change = 1'b0;
    if (pif.result_valid) begin
      if (pif.result != status_ff) begin
        if ((cnt_ff + 7'h01) >= run_len) begin
          nxt_status = pif.result;
          nxt_cnt    = 7'h00;
          nxt_change = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 7'h01;
        end
      end else begin
        // An agreeing result breaks the run.
        nxt_cnt = 7'h00;
      end
    end
  end

  // State registers.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff    <= 7'h00;
      status_ff <= 1'b0;
      change_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      status_ff <= nxt_status;
      change_ff <= nxt_change;
    end
  end

  assign pif.status        = status_ff;
  assign pif.status_change = change_ff;

endmodule // sagc_flicker_persist
